/* File: src/qspi_flash_cmd_subset.sv */
// Serial flash command decoder: secure region, software reset, deep sleep and 1-1-4 transfers.
`timescale 1ns/1ps
module qspi_flash_cmd_subset #(
    parameter int PAGE_BYTES = qspi_pkg::PAGE_BYTES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        csB,
    input  wire logic        sclk,
    input  wire logic [3:0]  ioIn,
    output logic      [3:0]  ioOut,
    output logic      [3:0]  ioOeB,
    input  wire logic        writeUnlocked,
    input  wire logic        nvAddr4Byte,
    output logic             addr4Byte,
    output logic             deepSleep,
    output logic             softResetPulse,
    output logic      [31:0] arrayAddr,
    input  wire logic [7:0]  arrayData,
    output logic             progValid,
    input  wire logic        progReady,
    output logic      [31:0] progAddr,
    output logic      [7:0]  progData,
    output logic             progOverrun
);
    localparam int PAGE_AW = $clog2(PAGE_BYTES);

    if (PAGE_BYTES != 256 && PAGE_BYTES != 512) begin : g_bad_page
        $error("Page size must be 256 or 512 bytes");
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Opcode classification.

    function automatic logic needsAddress(input logic [7:0] op);
        return op == qspi_pkg::OP_SECURE_PROGRAM || op == qspi_pkg::OP_SECURE_READ
            || op == qspi_pkg::OP_QUAD_READ_CFG  || op == qspi_pkg::OP_QUAD_READ_4B
            || op == qspi_pkg::OP_QUAD_PROG_CFG  || op == qspi_pkg::OP_QUAD_PROG_4B;
    endfunction : needsAddress

    function automatic logic isProgram(input logic [7:0] op);
        return op == qspi_pkg::OP_SECURE_PROGRAM || op == qspi_pkg::OP_QUAD_PROG_CFG
            || op == qspi_pkg::OP_QUAD_PROG_4B;
    endfunction : isProgram

    function automatic logic isQuadData(input logic [7:0] op);
        return op == qspi_pkg::OP_QUAD_READ_CFG || op == qspi_pkg::OP_QUAD_READ_4B
            || op == qspi_pkg::OP_QUAD_PROG_CFG || op == qspi_pkg::OP_QUAD_PROG_4B;
    endfunction : isQuadData

    function automatic logic fixedFourByte(input logic [7:0] op);
        return op == qspi_pkg::OP_QUAD_READ_4B || op == qspi_pkg::OP_QUAD_PROG_4B;
    endfunction : fixedFourByte

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection.

    logic       csS1;
    logic       csS2;
    logic       csPrevReg;
    logic       sclkS1;
    logic       sclkS2;
    logic       sclkS3;
    logic [3:0] ioS1;
    logic [3:0] ioS2;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            csS1      <= 1'b1;
            csS2      <= 1'b1;
            csPrevReg <= 1'b1;
            sclkS1    <= 1'b0;
            sclkS2    <= 1'b0;
            sclkS3    <= 1'b0;
            ioS1      <= 4'h0;
            ioS2      <= 4'h0;
        end else begin
            csS1      <= csB;
            csS2      <= csS1;
            csPrevReg <= csS2;
            sclkS1    <= sclk;
            sclkS2    <= sclkS1;
            sclkS3    <= sclkS2;
            ioS1      <= ioIn;
            ioS2      <= ioS1;
        end
    end

    logic csActive;
    logic frameEnd;
    logic sclkRise;
    logic sclkFall;

    assign csActive = !csS2;
    assign frameEnd = csS2 && !csPrevReg;
    assign sclkRise = csActive && sclkS2 && !sclkS3;
    assign sclkFall = csActive && !sclkS2 && sclkS3;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Receive shifter.

    qspi_pkg::phase_t phaseReg;
    logic [7:0]       opReg;
    logic [7:0]       rxReg;
    logic [7:0]       rxNext;
    logic [3:0]       bitCntReg;
    logic [3:0]       cntNext;
    logic             byteDone;
    logic             quadData;

    assign quadData = isQuadData(opReg);

    always_comb begin
        if (phaseReg == qspi_pkg::PH_WRITE && quadData) begin
            rxNext  = {rxReg[3:0], ioS2};                      // RQ7
            cntNext = bitCntReg + 4'h4;
        end else begin
            rxNext  = {rxReg[6:0], ioS2[0]};                   // RQ8
            cntNext = bitCntReg + 4'h1;
        end
    end

    assign byteDone = sclkRise && cntNext == qspi_pkg::BITS_PER_BYTE
                      && phaseReg != qspi_pkg::PH_SKIP && phaseReg != qspi_pkg::PH_READ;

    always_ff @(posedge clk_sys) begin
        if (!rst_b || !csActive) begin
            rxReg     <= 8'h00;
            bitCntReg <= 4'h0;
        end else if (sclkRise) begin
            rxReg     <= rxNext;
            bitCntReg <= byteDone ? 4'h0 : cntNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Transaction phase, opcode and address.

    logic [2:0]  addrLenReg;
    logic [2:0]  addrCntReg;
    logic [31:0] addrReg;
    logic        cmdValidReg;
    logic        progAllowedReg;
    logic        secWrEn;
    logic        pushValid;
    logic        readLoad;
    logic [7:0]  readByte;
    logic [7:0]  secureMem [qspi_pkg::SECURE_BYTES];

    assign secWrEn   = byteDone && phaseReg == qspi_pkg::PH_WRITE && opReg == qspi_pkg::OP_SECURE_PROGRAM;
    assign pushValid = byteDone && phaseReg == qspi_pkg::PH_WRITE && quadData;

    always_ff @(posedge clk_sys) begin
        if (!rst_b || !csActive) begin
            phaseReg       <= qspi_pkg::PH_CMD;
            addrCntReg     <= 3'h0;
            addrLenReg     <= qspi_pkg::ADDR_BYTES_SHORT;
            progAllowedReg <= 1'b0;
        end else if (byteDone && phaseReg == qspi_pkg::PH_CMD) begin
            addrCntReg     <= 3'h0;
            progAllowedReg <= writeUnlocked;
            addrLenReg     <= (fixedFourByte(rxNext) || addr4Byte) ? qspi_pkg::ADDR_BYTES_LONG
                                                                   : qspi_pkg::ADDR_BYTES_SHORT; // RQ6 RQ7
            if (deepSleep || !needsAddress(rxNext)) begin
                phaseReg <= qspi_pkg::PH_SKIP;
            end else if (isProgram(rxNext) && !writeUnlocked) begin
                phaseReg <= qspi_pkg::PH_SKIP;                 // RQ1 RQ7
            end else begin
                phaseReg <= qspi_pkg::PH_ADDR;                 // RQ2
            end
        end else if (byteDone && phaseReg == qspi_pkg::PH_ADDR) begin
            addrCntReg <= addrCntReg + 3'h1;
            if (addrCntReg + 3'h1 == addrLenReg) begin
                phaseReg <= isProgram(opReg) ? qspi_pkg::PH_WRITE : qspi_pkg::PH_READ;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            opReg       <= 8'h00;
            cmdValidReg <= 1'b0;
        end else if (frameEnd) begin
            cmdValidReg <= 1'b0;
        end else if (byteDone && phaseReg == qspi_pkg::PH_CMD) begin
            opReg       <= rxNext;
            cmdValidReg <= !deepSleep;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            addrReg <= 32'h0000_0000;
        end else if (byteDone && phaseReg == qspi_pkg::PH_CMD) begin
            // A three-byte address must leave the top byte zero, not the previous frame's bits.
            addrReg <= 32'h0000_0000;
        end else if (byteDone && phaseReg == qspi_pkg::PH_ADDR) begin
            addrReg <= {addrReg[23:0], rxNext};
        end else if (byteDone && phaseReg == qspi_pkg::PH_WRITE) begin
            addrReg[PAGE_AW-1:0] <= addrReg[PAGE_AW-1:0] + 1'b1;
        end else if (readLoad) begin
            addrReg <= addrReg + 32'h1;
        end
    end

    assign arrayAddr = addrReg;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Secure one-time region: programming only clears bits.

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            for (int i = 0; i < qspi_pkg::SECURE_BYTES; i++) begin
                secureMem[i] <= qspi_pkg::SECURE_ERASED;
            end
        end else if (secWrEn) begin
            secureMem[addrReg[qspi_pkg::SECURE_AW-1:0]] <= secureMem[addrReg[qspi_pkg::SECURE_AW-1:0]] & rxNext; // RQ1
        end
    end

    a_secure_prog_gate : assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ1
        secWrEn |-> progAllowedReg && phaseReg == qspi_pkg::PH_WRITE) else $error("Secure write without unlock");

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Transmit path: a new byte is fetched on the first falling edge of each byte.

    logic [7:0] txShiftReg;
    logic [3:0] txCntReg;
    logic [3:0] ioOutReg;

    assign readLoad = sclkFall && phaseReg == qspi_pkg::PH_READ && txCntReg == 4'h0;
    assign readByte = (opReg == qspi_pkg::OP_SECURE_READ) ? secureMem[addrReg[qspi_pkg::SECURE_AW-1:0]]
                                                          : arrayData; // RQ2

    always_ff @(posedge clk_sys) begin
        if (!rst_b || !csActive) begin
            txShiftReg <= 8'h00;
            txCntReg   <= 4'h0;
            ioOutReg   <= 4'h0;
        end else if (sclkFall && phaseReg == qspi_pkg::PH_READ) begin
            if (quadData) begin
                ioOutReg   <= readLoad ? readByte[7:4] : txShiftReg[7:4]; // RQ6
                txShiftReg <= readLoad ? {readByte[3:0], 4'h0} : {txShiftReg[3:0], 4'h0};
                txCntReg   <= readLoad ? 4'h4 : txCntReg - 4'h4;
            end else begin
                ioOutReg   <= {2'b00, readLoad ? readByte[7] : txShiftReg[7], 1'b0};
                txShiftReg <= readLoad ? {readByte[6:0], 1'b0} : {txShiftReg[6:0], 1'b0};
                txCntReg   <= readLoad ? 4'h7 : txCntReg - 4'h1;
            end
        end
    end

    assign ioOut = ioOutReg;
    assign ioOeB = (csActive && phaseReg == qspi_pkg::PH_READ) ? (quadData ? 4'h0 : 4'hD) : 4'hF;

    a_quad_read_lanes : assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ6
        (csActive && phaseReg == qspi_pkg::PH_READ && opReg == qspi_pkg::OP_QUAD_READ_CFG) |-> ioOeB == 4'h0)
        else $error("Quad read not driving four lanes");
    a_secure_read_lane : assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ2
        (csActive && phaseReg == qspi_pkg::PH_READ && opReg == qspi_pkg::OP_SECURE_READ) |-> ioOeB == 4'hD)
        else $error("Secure read not on single lane");
    a_cmd_single_lane : assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ8
        (phaseReg == qspi_pkg::PH_CMD || phaseReg == qspi_pkg::PH_ADDR) |-> ioOeB == 4'hF)
        else $error("Lanes driven during command or address");
    a_fixed_addr_len : assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ7
        (phaseReg == qspi_pkg::PH_ADDR && fixedFourByte(opReg)) |-> addrLenReg == qspi_pkg::ADDR_BYTES_LONG)
        else $error("Four-byte opcode with short address");

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Program FIFO towards the array programming logic.

    fifo_if #(.WIDTH(qspi_pkg::FIFO_WIDTH)) progIf ();

    assign progIf.data  = {addrReg, rxNext};
    assign progIf.valid = pushValid;                           // RQ7

    logic [qspi_pkg::FIFO_WIDTH-1:0] progWord;

    byte_fifo #(.WIDTH(qspi_pkg::FIFO_WIDTH), .DEPTH(qspi_pkg::FIFO_DEPTH)) u_prog_fifo (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wr      (progIf),
        .rdData  (progWord),
        .rdValid (progValid),
        .rdReady (progReady)
    );

    assign progAddr = progWord[39:8];
    assign progData = progWord[7:0];

    // A serial byte cannot be held back, so a full FIFO drops it and flags the frame.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            progOverrun <= 1'b0;
        end else if (pushValid && !progIf.ready) begin
            progOverrun <= 1'b1;
        end else if (byteDone && phaseReg == qspi_pkg::PH_CMD) begin
            progOverrun <= 1'b0;
        end
    end

    a_push_needs_unlock : assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ7
        pushValid |-> progAllowedReg && isProgram(opReg)) else $error("Program data pushed without unlock");

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Frame-end commands: reset arm, reset execute and deep sleep.

    logic armReg;
    logic reloadReg;
    logic cmdOnly;

    assign cmdOnly = frameEnd && cmdValidReg && phaseReg == qspi_pkg::PH_SKIP;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            armReg <= 1'b0;
        end else if (frameEnd) begin
            armReg <= cmdOnly && opReg == qspi_pkg::OP_RESET_ARM; // RQ3
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            softResetPulse <= 1'b0;
        end else begin
            softResetPulse <= cmdOnly && armReg && opReg == qspi_pkg::OP_RESET_EXECUTE; // RQ3
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reloadReg <= 1'b1;
            addr4Byte <= qspi_pkg::ADDR4_RESET;
        end else begin
            reloadReg <= 1'b0;
            if (reloadReg || softResetPulse) begin
                addr4Byte <= nvAddr4Byte;                      // RQ4
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            deepSleep <= qspi_pkg::DEEP_SLEEP_RESET;
        end else if (cmdOnly && opReg == qspi_pkg::OP_DEEP_SLEEP) begin
            deepSleep <= 1'b1;                                 // RQ5
        end
    end

    a_reset_needs_arm : assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ3
        softResetPulse |-> $past(armReg) && $past(opReg) == qspi_pkg::OP_RESET_EXECUTE)
        else $error("Software reset without arm");
    a_reset_reloads : assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ4
        softResetPulse |=> addr4Byte == $past(nvAddr4Byte)) else $error("Config not reloaded on reset");
    a_sleep_entry : assert property (@(posedge clk_sys) disable iff (!rst_b) // RQ5
        $rose(deepSleep) |-> $past(opReg) == qspi_pkg::OP_DEEP_SLEEP && $past(frameEnd))
        else $error("Deep sleep entered without its command");

endmodule : qspi_flash_cmd_subset

/* File: src/qspi_pkg.sv */
// Constants, opcodes and phase type for the serial flash command subset.
//
// Behaviour
// [RQ1] Secure region program needs prior write unlock; address then bytes program 1024-byte region.
// [RQ2] Opcode 4B with 3 or 4 address bytes reads the secure region without unlock.
// [RQ3] Reset execute 99 acts only when the previous transaction was reset arm 66.
// [RQ4] A valid software reset reloads volatile configuration from its nonvolatile default.
// [RQ5] Opcode B9 alone enters deep sleep, the lowest power state.
// [RQ6] Quad output read streams array data on four lanes; 6B configured, 6C four-byte address.
// [RQ7] Quad input program needs write unlock; 32 configured, 34 four-byte address, page data.
// [RQ8] Command and address arrive on one lane MSB first; only data uses four lanes.
package qspi_pkg;

    localparam logic [7:0] OP_SECURE_PROGRAM = 8'hA5;
    localparam logic [7:0] OP_SECURE_READ    = 8'h4B;
    localparam logic [7:0] OP_RESET_ARM      = 8'h66;
    localparam logic [7:0] OP_RESET_EXECUTE  = 8'h99;
    localparam logic [7:0] OP_DEEP_SLEEP     = 8'hB9;
    localparam logic [7:0] OP_QUAD_READ_CFG  = 8'h6B;
    localparam logic [7:0] OP_QUAD_READ_4B   = 8'h6C;
    localparam logic [7:0] OP_QUAD_PROG_CFG  = 8'h32;
    localparam logic [7:0] OP_QUAD_PROG_4B   = 8'h34;

    localparam int         SECURE_BYTES      = 1024;
    localparam int         SECURE_AW         = 10;
    localparam int         PAGE_BYTES        = 256;
    localparam int         FIFO_DEPTH        = 8;
    localparam int         FIFO_WIDTH        = 40;
    localparam logic [2:0] ADDR_BYTES_SHORT  = 3'h3;
    localparam logic [2:0] ADDR_BYTES_LONG   = 3'h4;
    localparam logic [3:0] BITS_PER_BYTE     = 4'h8;
    localparam logic       ADDR4_RESET       = 1'b0;
    localparam logic       DEEP_SLEEP_RESET  = 1'b0;
    localparam logic [7:0] SECURE_ERASED     = 8'hFF;

    typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_WRITE, PH_READ, PH_SKIP} phase_t;

endpackage : qspi_pkg

/* File: src/fifo_if.sv */
// Valid and ready carrier between the command block and its program FIFO.
`timescale 1ns/1ps
interface fifo_if #(
    parameter int WIDTH = 8
) ();
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : fifo_if

/* File: src/byte_fifo.sv */
// Synchronous FIFO holding program address and data words.
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = qspi_pkg::FIFO_WIDTH,
    parameter int DEPTH = qspi_pkg::FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    fifo_if.snk                   wr,
    output logic [WIDTH-1:0]      rdData,
    output logic                  rdValid,
    input  wire logic             rdReady
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtrReg;
    logic [AW:0]      rdPtrReg;
    logic             full;
    logic             empty;

    assign full     = (wrPtrReg[AW] != rdPtrReg[AW]) && (wrPtrReg[AW-1:0] == rdPtrReg[AW-1:0]);
    assign empty    = wrPtrReg == rdPtrReg;
    assign wr.ready = !full;
    assign rdValid  = !empty;
    assign rdData   = mem[rdPtrReg[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wrPtrReg <= '0;
        end else if (wr.valid && !full) begin
            wrPtrReg <= wrPtrReg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wr.valid && !full) begin
            mem[wrPtrReg[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdPtrReg <= '0;
        end else if (rdReady && !empty) begin
            rdPtrReg <= rdPtrReg + 1'b1;
        end
    end

    a_fifo_no_overfill : assert property (@(posedge clk_sys) disable iff (!rst_b)
        (full && wr.valid) |=> $stable(wrPtrReg)) else $error("FIFO written while full");

endmodule : byte_fifo

/* File: test/spi_host.sv */
// Behavioural host controller that drives the serial flash link in mode 0.
`timescale 1ns/1ps
module spi_host (
    input  wire logic       clk_sys,
    input  wire logic [3:0] ioOut,
    input  wire logic [3:0] ioOeB,
    output logic            csB,
    output logic            sclk,
    output logic      [3:0] ioIn
);
    initial begin
        csB  = 1'b1;
        sclk = 1'b0;
        ioIn = 4'h0;
    end
    // Eight system cycles per half period give the 64 ns link clock.
    task automatic half();
        repeat (8) @(posedge clk_sys);
    endtask : half
    task automatic edge_out(input logic [3:0] lanes);
        sclk <= 1'b0;
        ioIn <= lanes;
        half();
        sclk <= 1'b1;
        half();
    endtask : edge_out
    task automatic start();
        csB <= 1'b0;
        half();
    endtask : start
    // The link clock stands still low between frames.
    task automatic stop();
        sclk <= 1'b0;
        half();
        csB <= 1'b1;
        half();
    endtask : stop
    task automatic send_bits(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            edge_out({{3{~v[i]}}, v[i]});
        end
    endtask : send_bits
    task automatic send_quad(input logic [7:0] v);
        edge_out(v[7:4]);
        edge_out(v[3:0]);
    endtask : send_quad
    task automatic cmd(input logic [7:0] op);
        start();
        send_bits({24'h0, op}, 8);
        stop();
    endtask : cmd
    // Released lanes toggle every bit so a stale level is never mistaken for data.
    task automatic read_lanes(input int n, input logic quad, output logic [7:0] v);
        for (int i = 0; i < n; i++) begin
            edge_out(~ioIn);
            if (quad) begin
                v = {v[3:0], (ioOut & ~ioOeB) | (ioIn & ioOeB)};
            end else begin
                v = {v[6:0], ioOeB[1] ? ioIn[1] : ioOut[1]};
            end
        end
    endtask : read_lanes
endmodule : spi_host

/* File: test/testbench.sv */
// Self-checking bench for the serial flash command decoder.
`timescale 1ns/1ps
module testbench;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        writeUnlocked = 1'b0;
    logic        nvAddr4Byte = 1'b0;
    logic [7:0]  arrayData = 8'h00;
    logic        progReady = 1'b0;
    logic        csB, sclk, addr4Byte, deepSleep, softResetPulse, progValid, progOverrun;
    logic [3:0]  ioIn, ioOut, ioOeB;
    logic [31:0] arrayAddr, progAddr;
    logic [7:0]  progData;
    int          failures = 0;
    int          cmp_count = 0;
    int          pulses = 0;

    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) arrayData <= arrayAddr[7:0] ^ 8'h5A;
    always @(posedge clk_sys) if (softResetPulse === 1'b1) pulses <= pulses + 1;

    spi_host host (.clk_sys(clk_sys), .ioOut(ioOut), .ioOeB(ioOeB), .csB(csB), .sclk(sclk), .ioIn(ioIn));
    qspi_flash_cmd_subset #(.PAGE_BYTES(256)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .csB(csB), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut),
        .ioOeB(ioOeB), .writeUnlocked(writeUnlocked), .nvAddr4Byte(nvAddr4Byte), .addr4Byte(addr4Byte),
        .deepSleep(deepSleep), .softResetPulse(softResetPulse), .arrayAddr(arrayAddr), .arrayData(arrayData),
        .progValid(progValid), .progReady(progReady), .progAddr(progAddr), .progData(progData),
        .progOverrun(progOverrun));

    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check("idle enables", 4'hF, ioOeB);
        check("deep sleep", 1'b0, deepSleep);
        check("address length", nvAddr4Byte, addr4Byte);
    endtask : do_reset
    task automatic t_quad_read(input logic [7:0] op, input logic [31:0] addr, input int nbits);
        logic [7:0] v;
        host.start();
        host.send_bits({24'h0, op}, 8);
        host.send_bits(addr, nbits);
        for (int k = 0; k < 2; k++) begin
            host.read_lanes(2, 1'b1, v);
            check("quad data", 8'((addr[7:0] + k[7:0]) ^ 8'h5A), v);
        end
        check("quad enables", 4'h0, ioOeB);
        host.stop();
        check("released enables", 4'hF, ioOeB);
    endtask : t_quad_read
    task automatic sec_read(input logic [23:0] addr, input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] v0, v1;
        host.start();
        host.send_bits({24'h0, qspi_pkg::OP_SECURE_READ}, 8);
        host.send_bits({8'h00, addr}, 24);
        host.read_lanes(8, 1'b0, v0);
        host.read_lanes(8, 1'b0, v1);
        check("secure enables", 4'hD, ioOeB);
        host.stop();
        check("secure data", {e0, e1}, {v0, v1});
    endtask : sec_read
    task automatic sec_prog(input logic unlock, input logic [7:0] d0, input logic [7:0] d1);
        writeUnlocked <= unlock;
        host.start();
        host.send_bits({24'h0, qspi_pkg::OP_SECURE_PROGRAM}, 8);
        host.send_bits(32'h000010, 24);
        host.send_bits({16'h0, d0, d1}, 16);
        host.stop();
    endtask : sec_prog
    task automatic t_secure();
        sec_read(24'h000010, 8'hFF, 8'hFF);
        sec_prog(1'b0, 8'h00, 8'h00);
        sec_read(24'h000010, 8'hFF, 8'hFF);
        sec_prog(1'b1, 8'h3C, 8'hF0);
        sec_read(24'h000010, 8'h3C, 8'hF0);
    endtask : t_secure
    task automatic t_quad_prog(input logic unlock, input logic [7:0] op, input logic [31:0] addr, input int nbits);
        int k;
        writeUnlocked <= unlock;
        host.start();
        host.send_bits({24'h0, op}, 8);
        host.send_bits(addr, nbits);
        for (int i = 0; i < 9; i++) begin
            host.send_quad(8'hA0 + i[7:0]);
        end
        host.stop();
        check("overrun", unlock, progOverrun);
        k = 0;
        progReady <= 1'b1;
        for (int c = 0; c < 30 && k < 8; c++) begin
            @(posedge clk_sys);
            if (progValid === 1'b1) begin
                check("program word", {addr[31:8], addr[7:0] + k[7:0], 8'hA0 + k[7:0]}, {progAddr, progData});
                k++;
            end
        end
        progReady <= 1'b0;
        @(posedge clk_sys);
        check("words drained", unlock ? 8 : 0, k);
        check("fifo empty", 1'b0, progValid);
    endtask : t_quad_prog
    task automatic t_soft_reset();
        int p;
        nvAddr4Byte <= 1'b1;
        p = pulses;
        host.cmd(qspi_pkg::OP_RESET_EXECUTE);
        host.cmd(qspi_pkg::OP_RESET_ARM);
        host.cmd(8'h00);
        host.cmd(qspi_pkg::OP_RESET_EXECUTE);
        check("ignored reset", p, pulses);
        check("length kept", 1'b0, addr4Byte);
        host.cmd(qspi_pkg::OP_RESET_ARM);
        host.cmd(qspi_pkg::OP_RESET_EXECUTE);
        check("reset pulse", p + 1, pulses);
        check("length reloaded", 1'b1, addr4Byte);
        t_quad_read(qspi_pkg::OP_QUAD_READ_CFG, 32'h000010FF, 32);
    endtask : t_soft_reset
    task automatic t_deep_sleep();
        logic [7:0] v;
        int p;
        host.cmd(qspi_pkg::OP_DEEP_SLEEP);
        check("deep sleep", 1'b1, deepSleep);
        p = pulses;
        host.cmd(qspi_pkg::OP_RESET_ARM);
        host.cmd(qspi_pkg::OP_RESET_EXECUTE);
        host.start();
        host.send_bits({24'h0, qspi_pkg::OP_QUAD_READ_4B}, 8);
        host.send_bits(32'h00000040, 32);
        host.read_lanes(2, 1'b1, v);
        check("asleep enables", 4'hF, ioOeB);
        host.stop();
        check("asleep reset", p, pulses);
    endtask : t_deep_sleep

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk_sys);
        failures++;
        final_report();
    end
    initial begin
        do_reset();
        t_quad_read(qspi_pkg::OP_QUAD_READ_CFG, 32'h00ABCDFF, 24);
        t_quad_read(qspi_pkg::OP_QUAD_READ_4B, 32'h123456FF, 32);
        t_secure();
        t_quad_prog(1'b0, qspi_pkg::OP_QUAD_PROG_CFG, 32'h001234FC, 24);
        t_quad_prog(1'b1, qspi_pkg::OP_QUAD_PROG_CFG, 32'h001234FC, 24);
        t_quad_prog(1'b1, qspi_pkg::OP_QUAD_PROG_4B, 32'h89ABCDFC, 32);
        t_soft_reset();
        t_deep_sleep();
        do_reset();
        final_report();
    end
endmodule : testbench
